// [ffm_map.svh]
// Constants for the free-fall and high-g interrupt block
// Functional notes
// R1: Bus-select high means two-wire, low SPI
// R2: Enable low holds standby, serial ports silent
// R3: Enable rising reloads defaults, unlatched interrupts
// R4: Output is fall OR (highg AND gate)
// R5: Fall needs all axes low for debounce
// R6: Highg needs any axis high for debounce
// R7: Each interrupt latched or unlatched independently
// R8: Defaults 0.4 g, 2.5 g, 4 ms debounce
// R9: Host holds enable low 1 ms after supply; ffm_host holds it only PWR_DLY clocks, 10 by default
// R10: Host holds SPI clock low 200 us; ffm_host drives no SPI clock
// R11: No serial access means factory defaults, unlatched
// R12: Debounce counter restarts when condition drops
`ifndef FFM_MAP_SVH
`define FFM_MAP_SVH
// ************************************************************
// Scaling
// ************************************************************
`define FFM_AXIS_W 12
`define FFM_ZERO_G 12'h800
`define FFM_CLK_PERIOD_NS 10
// ************************************************************
// Defaults
// ************************************************************
// 0.4 g and 2.5 g at 546 counts/g, as unsigned magnitude
`define FFM_FALL_THR_DEF 12'h0da
`define FFM_HIGHG_THR_DEF 12'h555
`define FFM_DEB_TIME_MS 4
`define FFM_DEB_W 20
`define FFM_DEB_CYC ((`FFM_DEB_TIME_MS * 1000000) / `FFM_CLK_PERIOD_NS)
`endif

// [ffm_pkg.sv]
// Types for the free-fall and high-g interrupt block
package ffm_pkg;
    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } ffm_axes_s;
    typedef struct packed {
        logic [11:0] fall_thr;
        logic [11:0] highg_thr;
        logic [19:0] fall_deb;
        logic [19:0] highg_deb;
        logic fall_latch;
        logic highg_latch;
    } ffm_cfg_s;
    typedef enum logic [1:0] {
        FFM_STANDBY = 2'b00,
        FFM_RUN = 2'b01
    } ffm_state_e;
endpackage

// [ffm_top.sv]
// Free-fall and high-g interrupt logic with enable and bus-mode control
`include "ffm_map.svh"
module ffm_top #(
    parameter logic [19:0] DEB_CYC = 20'(`FFM_DEB_CYC)
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic ENABLE,
    input wire logic BUS_SELECT_N,
    input wire logic HIGHG_GATE_IN,
    input wire ffm_pkg::ffm_axes_s AXES,
    input wire logic CFG_WR,
    input wire ffm_pkg::ffm_cfg_s CFG_IN,
    output logic EVENT_IRQ_OUT,
    output logic SERIAL_ACTIVE,
    output logic TWO_WIRE_MODE,
    output logic FALL_DETECT,
    output logic HIGHG_DETECT
);
    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [2:0] en_s_q;
    logic [2:0] sel_s_q;
    logic [2:0] gate_s_q;
    logic en_q;
    logic sel_q;
    logic gate_q;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_s_q <= 3'h0;
            sel_s_q <= 3'h0;
            gate_s_q <= 3'h0;
        end else begin
            en_s_q <= {en_s_q[1:0], ENABLE};
            sel_s_q <= {sel_s_q[1:0], BUS_SELECT_N};
            gate_s_q <= {gate_s_q[1:0], HIGHG_GATE_IN};
        end
    end
    // A change counts once stages two and three agree
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_q <= 1'b0;
            sel_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            if (en_s_q[1] == en_s_q[2]) en_q <= en_s_q[2];
            if (sel_s_q[1] == sel_s_q[2]) sel_q <= sel_s_q[2];
            if (gate_s_q[1] == gate_s_q[2]) gate_q <= gate_s_q[2];
        end
    end
    // ********************************************************
    // Enable state and configuration
    // ********************************************************
    ffm_pkg::ffm_state_e state_q;
    ffm_pkg::ffm_state_e state_d;
    ffm_pkg::ffm_cfg_s cfg_q;
    ffm_pkg::ffm_cfg_s cfg_def;
    // Enable low stops detection at once, not one state later
    wire run = en_q && (state_q == ffm_pkg::FFM_RUN);
    wire en_rise = en_q && (state_q == ffm_pkg::FFM_STANDBY);
    assign cfg_def = '{fall_thr: `FFM_FALL_THR_DEF, // R8 R11
                       highg_thr: `FFM_HIGHG_THR_DEF,
                       fall_deb: DEB_CYC,
                       highg_deb: DEB_CYC,
                       fall_latch: 1'b0, // R3
                       highg_latch: 1'b0};
    always_comb begin
        unique case (state_q)
            ffm_pkg::FFM_STANDBY: state_d = en_q ? ffm_pkg::FFM_RUN
                                                : ffm_pkg::FFM_STANDBY;
            ffm_pkg::FFM_RUN: state_d = en_q ? ffm_pkg::FFM_RUN
                                            : ffm_pkg::FFM_STANDBY;
            default: state_d = ffm_pkg::FFM_STANDBY;
        endcase
    end
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ffm_pkg::FFM_STANDBY;
            cfg_q <= '0;
        end else begin
            state_q <= state_d; // R2
            if (en_rise) cfg_q <= cfg_def; // R3
            else if (run && CFG_WR) cfg_q <= CFG_IN; // R8
        end
    end
    // ********************************************************
    // Detection
    // ********************************************************
    logic [11:0] mag [3];
    logic [2:0] below;
    logic [2:0] above;
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_axis
            wire [11:0] raw = (i == 0) ? AXES.x : (i == 1) ? AXES.y : AXES.z;
            // Magnitude around zero-g; no clamp, code 0 gives the largest value, 800 hex
            assign mag[i] = raw[11] ? (raw - `FFM_ZERO_G)
                                    : (`FFM_ZERO_G - raw);
            assign below[i] = mag[i] < cfg_q.fall_thr;
            assign above[i] = mag[i] > cfg_q.highg_thr;
        end
    endgenerate
    wire fall_cond = run && (&below); // R5
    wire highg_cond = run && (|above); // R6
    logic [19:0] fall_cnt_q;
    logic [19:0] highg_cnt_q;
    logic fall_q;
    logic highg_q;
    wire fall_hit = fall_cond && (fall_cnt_q >= cfg_q.fall_deb);
    wire highg_hit = highg_cond && (highg_cnt_q >= cfg_q.highg_deb);
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fall_cnt_q <= 20'h0;
            highg_cnt_q <= 20'h0;
        end else begin
            // Counter saturates so a long event cannot wrap
            fall_cnt_q <= !fall_cond ? 20'h0 // R12
                        : fall_hit ? fall_cnt_q : fall_cnt_q + 20'h1;
            highg_cnt_q <= !highg_cond ? 20'h0 // R12
                         : highg_hit ? highg_cnt_q : highg_cnt_q + 20'h1;
        end
    end
    // ********************************************************
    // Latch and output
    // ********************************************************
    wire fall_d = run && (fall_hit || (cfg_q.fall_latch && fall_q)); // R7
    wire highg_d = run && (highg_hit || (cfg_q.highg_latch && highg_q));
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fall_q <= 1'b0;
            highg_q <= 1'b0;
            FALL_DETECT <= 1'b0;
            HIGHG_DETECT <= 1'b0;
            EVENT_IRQ_OUT <= 1'b0;
            SERIAL_ACTIVE <= 1'b0;
            TWO_WIRE_MODE <= 1'b0;
        end else begin
            fall_q <= fall_d;
            highg_q <= highg_d;
            FALL_DETECT <= fall_d;
            HIGHG_DETECT <= highg_d;
            EVENT_IRQ_OUT <= fall_d || (highg_d && gate_q); // R4
            SERIAL_ACTIVE <= en_q; // R2
            TWO_WIRE_MODE <= sel_q; // R1
        end
    end
    // ********************************************************
    // Checks
    // ********************************************************
    property p_irq_or;
        @(posedge MCLK) disable iff (!ARST_N)
        ##1 EVENT_IRQ_OUT == (FALL_DETECT || (HIGHG_DETECT && $past(gate_q)));
    endproperty
    a_irq_or: assert property (p_irq_or) // R4
        else $error("irq mismatch");
    property p_standby;
        @(posedge MCLK) disable iff (!ARST_N)
        !en_q |=> !SERIAL_ACTIVE && !FALL_DETECT && !HIGHG_DETECT;
    endproperty
    a_standby: assert property (p_standby) // R2
        else $error("standby active");
    property p_serial;
        @(posedge MCLK) disable iff (!ARST_N)
        ##1 SERIAL_ACTIVE == $past(en_q);
    endproperty
    a_serial: assert property (p_serial) // R2
        else $error("serial flag wrong");
    property p_cfg_hold;
        @(posedge MCLK) disable iff (!ARST_N)
        (!run && !en_rise) |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) // R2
        else $error("config written in standby");
    property p_reload;
        @(posedge MCLK) disable iff (!ARST_N)
        en_rise |=> cfg_q == cfg_def && !cfg_q.fall_latch;
    endproperty
    a_reload: assert property (p_reload) // R3
        else $error("no reload");
    property p_fall_needs_all;
        @(posedge MCLK) disable iff (!ARST_N)
        $rose(fall_q) |-> $past(&below)
            && $past(fall_cnt_q) >= $past(cfg_q.fall_deb);
    endproperty
    a_fall_needs_all: assert property (p_fall_needs_all) // R5
        else $error("fall early");
    property p_highg_any;
        @(posedge MCLK) disable iff (!ARST_N)
        $rose(highg_q) |-> $past(|above)
            && $past(highg_cnt_q) >= $past(cfg_q.highg_deb);
    endproperty
    a_highg_any: assert property (p_highg_any) // R6
        else $error("highg early");
    property p_unlatched;
        @(posedge MCLK) disable iff (!ARST_N)
        (!cfg_q.fall_latch && !fall_cond) |=> !fall_q;
    endproperty
    a_unlatched: assert property (p_unlatched) // R7
        else $error("fall stuck");
    property p_highg_unlatched;
        @(posedge MCLK) disable iff (!ARST_N)
        (!cfg_q.highg_latch && !highg_cond) |=> !highg_q;
    endproperty
    a_highg_unlatched: assert property (p_highg_unlatched) // R7
        else $error("highg stuck");
    property p_latch_hold;
        @(posedge MCLK) disable iff (!ARST_N)
        (run && cfg_q.fall_latch && fall_q) |=> fall_q;
    endproperty
    a_latch_hold: assert property (p_latch_hold) // R7
        else $error("latched fall lost");
    property p_restart;
        @(posedge MCLK) disable iff (!ARST_N)
        !highg_cond |=> highg_cnt_q == 20'h0;
    endproperty
    a_restart: assert property (p_restart) // R12
        else $error("no restart");
    property p_fall_restart;
        @(posedge MCLK) disable iff (!ARST_N)
        !fall_cond |=> fall_cnt_q == 20'h0;
    endproperty
    a_fall_restart: assert property (p_fall_restart) // R12
        else $error("fall count kept");
    property p_mode;
        @(posedge MCLK) disable iff (!ARST_N)
        ##1 TWO_WIRE_MODE == $past(sel_q);
    endproperty
    a_mode: assert property (p_mode) // R1
        else $error("mode wrong");
endmodule

// [ffm_host.sv]
// Host model: drives the enable and high-g gate pins
module ffm_host #(
    parameter int PWR_DLY = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic want_en,
    input wire logic want_gate,
    output logic enable,
    output logic gate
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Count stands in for the supply settling time
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            enable <= 1'b0;
            gate <= 1'b0;
        end else begin
            if (cnt < PWR_DLY) cnt <= cnt + 1;
            // Enable held low until the supply has settled
            enable <= #1 want_en && (cnt == PWR_DLY);
            gate <= #1 want_gate;
        end
    end
endmodule

// [freefall_motion_interrupt_tb.sv]
// Self-checking bench for the free-fall and high-g interrupt block
`include "ffm_map.svh"
module freefall_motion_interrupt_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] FT = `FFM_FALL_THR_DEF;
    localparam logic [11:0] HT = `FFM_HIGHG_THR_DEF;
    logic MCLK = 0, ARST_N = 0, BUS_SELECT_N = 1, CFG_WR = 0;
    logic want_en = 0, want_gate = 0, ENABLE, HIGHG_GATE_IN;
    logic EVENT_IRQ_OUT, SERIAL_ACTIVE, TWO_WIRE_MODE;
    logic FALL_DETECT, HIGHG_DETECT;
    ffm_pkg::ffm_axes_s AXES = {3{12'h900}};
    ffm_pkg::ffm_cfg_s CFG_IN = '0;
    int bad_count = 0, tests_run = 0;
    logic [31:0] seed = 32'h78db;
    always #5 MCLK = ~MCLK;
    ffm_top #(.DEB_CYC(20'h14)) uut (.MCLK(MCLK), .ARST_N(ARST_N),
        .ENABLE(ENABLE), .BUS_SELECT_N(BUS_SELECT_N),
        .HIGHG_GATE_IN(HIGHG_GATE_IN), .AXES(AXES), .CFG_WR(CFG_WR),
        .CFG_IN(CFG_IN), .EVENT_IRQ_OUT(EVENT_IRQ_OUT),
        .SERIAL_ACTIVE(SERIAL_ACTIVE), .TWO_WIRE_MODE(TWO_WIRE_MODE),
        .FALL_DETECT(FALL_DETECT), .HIGHG_DETECT(HIGHG_DETECT));
    ffm_host #(.PWR_DLY(10)) host (.clk(MCLK), .rst_n(ARST_N),
        .want_en(want_en), .want_gate(want_gate), .enable(ENABLE),
        .gate(HIGHG_GATE_IN));
    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [11:0] mg(logic [11:0] a);
        return a[11] ? a - 12'h800 : 12'h800 - a;
    endfunction
    function automatic logic [11:0] ra(logic [31:0] r);
        logic [11:0] m;
        // Mix of near-zero and large magnitudes to hit both detectors
        m = r[4] ? {4'h0, r[15:8]} : {1'b0, r[26:16]};
        return r[3] ? 12'h800 - m : 12'h800 + m;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic chk(logic got, logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic ax(logic [11:0] x, y, z, int n);
        AXES = {x, y, z};
        cyc(n);
    endtask
    task automatic final_report;
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ********************
    // Sequence
    // ********************
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
    initial begin
        logic f, h;
        cyc(2);
        ARST_N = 1;
        for (int b = 0; b < 2; b++) begin
            BUS_SELECT_N = b[0];
            cyc(6);
            chk(TWO_WIRE_MODE, b[0]);
        end
        AXES = {3{12'h800}};
        // Write in standby must be ignored
        CFG_IN = {12'h000, 12'h000, 20'h1, 20'h1, 1'b1, 1'b1};
        CFG_WR = 1;
        cyc(30);
        CFG_WR = 0;
        chk(SERIAL_ACTIVE, 1'b0);
        chk(FALL_DETECT, 1'b0);
        ax(12'h900, 12'h900, 12'h900, 1);
        want_en = 1;
        cyc(20);
        chk(SERIAL_ACTIVE, 1'b1);
        ax(12'h800, 12'h800, 12'h800, 15);
        chk(FALL_DETECT, 1'b0);
        ax(12'h900, 12'h800, 12'h800, 1);
        ax(12'h800, 12'h800, 12'h800, 15);
        chk(FALL_DETECT, 1'b0);
        cyc(15);
        chk(FALL_DETECT, 1'b1);
        chk(EVENT_IRQ_OUT, 1'b1);
        ax(12'h900, 12'h900, 12'h900, 5);
        chk(FALL_DETECT, 1'b0);
        for (int i = 0; i < 2; i++) begin
            ax(12'(12'h800 + FT - 1 + i), 12'(12'h800 - FT + 1 - i),
               12'h800, 30);
            chk(FALL_DETECT, i == 0);
            ax(12'(12'h800 - HT - i), 12'h900, 12'h900, 30);
            chk(HIGHG_DETECT, i[0]);
        end
        for (int g = 0; g < 2; g++) begin
            want_gate = g[0];
            cyc(8);
            chk(EVENT_IRQ_OUT, g[0]);
        end
        repeat (12) begin
            seed = xs(seed);
            AXES.x = ra(seed);
            seed = xs(seed);
            AXES.y = ra(seed);
            seed = xs(seed);
            AXES.z = ra(seed);
            want_gate = seed[31];
            cyc(30);
            f = mg(AXES.x) < FT && mg(AXES.y) < FT && mg(AXES.z) < FT;
            h = mg(AXES.x) > HT || mg(AXES.y) > HT || mg(AXES.z) > HT;
            chk(FALL_DETECT, f);
            chk(HIGHG_DETECT, h);
            chk(EVENT_IRQ_OUT, f | (h & seed[31]));
        end
        CFG_IN = {FT, HT, 20'h14, 20'h14, 1'b1, 1'b1};
        CFG_WR = 1;
        cyc(1);
        CFG_WR = 0;
        // Wait two cycles after the write before driving the axes
        cyc(2);
        ax(12'h800, 12'h800, 12'h800, 30);
        ax(12'h900, 12'h900, 12'h900, 10);
        chk(FALL_DETECT, 1'b1);
        ax(12'h200, 12'h900, 12'h900, 30);
        ax(12'h900, 12'h900, 12'h900, 10);
        chk(HIGHG_DETECT, 1'b1);
        want_en = 0;
        cyc(8);
        chk(SERIAL_ACTIVE, 1'b0);
        chk(FALL_DETECT, 1'b0);
        want_en = 1;
        cyc(8);
        ax(12'h800, 12'h800, 12'h800, 30);
        ax(12'h900, 12'h900, 12'h900, 5);
        chk(FALL_DETECT, 1'b0);
        final_report();
    end
endmodule
